// [include/tap_pkg.sv]
// Shared constants and types for both ends of the test access port link.
//
// Summary of operation
// - Compliance pin low selects test, high debug.
// - Debug mode holds all test logic in reset.
// - Mode select sampled each rising test clock.
// - Serial data in sampled on rising edges.
// - Data out driven only when shifting, falling-edge.
// - Low test reset forces reset state asynchronously.
// - Full sixteen-state controller plus data registers.
// - Three-bit instruction shift, hold on update.
// - Instruction MSB nearest input, LSB out first.
// - Code 000 scan chain, cells drive, reset.
// - Instructions take effect at update falling edge.
// - Code 001 selects 32-bit identification register.
// - Code 100 scan chain, pins left undisturbed.
// - Code 101 bypass, pins high-Z, reset.
// - Code 110 bypass, cells drive, reset.
// - Code 111 bypass with no functional effect.
// - Identification capture loads LSB with one.
// - Other identification bits capture fixed constants.
// - Entering reset state loads identification instruction.
// - Instruction capture loads value 001.
// - Test logic static, runs only on test clock; the code passes pin controls through core-clock synchronisers.
// - Bypass stage captures zero in capture state.
package tap_pkg;

	// ****************************************************************
	// Register sizes and instruction codes
	// ****************************************************************
	localparam int IR_WIDTH = 3;
	localparam int ID_WIDTH = 32;
	localparam logic [2:0] INS_EXTEST = 3'h0;
	localparam logic [2:0] INS_IDCODE = 3'h1;
	localparam logic [2:0] INS_SAMPLE = 3'h4;
	localparam logic [2:0] INS_HIGHZ  = 3'h5;
	localparam logic [2:0] INS_CLAMP  = 3'h6;
	localparam logic [2:0] INS_BYPASS = 3'h7;
	localparam logic [2:0] IR_RESET   = INS_IDCODE;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	// Identification value; the value is arbitrary, bit 0 must be one.
	localparam logic [31:0] ID_DEFAULT = 32'h0A5C_3001;

	// ****************************************************************
	// Controller states
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
		ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
		ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} tap_state_e;

	// ****************************************************************
	// Host sequencing
	// ****************************************************************
	typedef enum logic [1:0] {
		OP_RESET, OP_IR, OP_DR
	} tap_op_e;
	localparam int CORE_PERIOD_NS = 10;
	localparam int TCK_PERIOD_NS  = 160;
	localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CORE_PERIOD_NS);
	localparam logic [2:0] RESET_HIGH_STEPS = 3'h5;
	localparam logic [5:0] RESET_LAST_STEP  = 6'h05;
	localparam logic [2:0] PRE_STEPS_IR = 3'h4;
	localparam logic [2:0] PRE_STEPS_DR = 3'h3;
	localparam logic [3:0] PRE_TMS_IR = 4'h3;
	localparam logic [3:0] PRE_TMS_DR = 4'h1;

endpackage

// [include/jtag_link_if.sv]
// Test access port wires between the tester and the device.
`timescale 1ns/1ps
interface jtag_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic dbg_mode;
	logic tdo;
	logic tdo_oe;
	logic tdo_line;

	// Undriven data out floats high at the tester's pull-up.
	assign tdo_line = tdo_oe ? tdo : 1'b1;

	modport host (
		output tck,
		output tms,
		output tdi,
		output trst_n,
		output dbg_mode,
		input  tdo_line
	);

	modport device (
		input  tck,
		input  tms,
		input  tdi,
		input  trst_n,
		input  dbg_mode,
		output tdo,
		output tdo_oe
	);
endinterface

// [rtl/tap_device.sv]
// Device end: controller, instruction register, data registers, decode.
`timescale 1ns/1ps
module tap_device
	import tap_pkg::*;
#(
	parameter logic [31:0] ID_CODE = ID_DEFAULT
) (
	jtag_link_if.device link,
	input  wire logic  i_core_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_bsr_tdo,
	output logic       o_bsr_tdi,
	output logic       o_bsr_select,
	output logic       o_bsr_capture,
	output logic       o_bsr_shift,
	output logic       o_bsr_update,
	output logic       o_func_reset,
	output logic       o_pins_highz,
	output logic       o_pins_from_cells
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (ID_CODE[0] !== 1'b1) begin : g_bad_id
		$error("Identification value must have bit 0 set.");
	end

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef struct packed {
		tap_state_e             state;
		logic [IR_WIDTH-1:0]    ir_shift;
		logic [ID_WIDTH-1:0]    id_shift;
		logic                   bypass;
	} pos_s;

	typedef struct packed {
		logic [IR_WIDTH-1:0]    ir_hold;
		logic                   tdo;
		logic                   tdo_oe;
	} neg_s;

	typedef struct packed {
		logic [2:0]             meta;
		logic [2:0]             stable;
	} core_s;

	localparam pos_s POS_RESET = '{state: ST_TLR, ir_shift: IR_RESET,
		id_shift: '0, bypass: 1'b0};
	localparam neg_s NEG_RESET = '{ir_hold: IR_RESET, tdo: 1'b0, tdo_oe: 1'b0};

	pos_s  pos;
	pos_s  next_pos;
	neg_s  neg;
	neg_s  next_neg;
	core_s core;
	core_s next_core;
	logic  tap_rst_n;
	logic  sel_bsr;
	logic  sel_id;
	logic  func_reset;
	logic  pins_highz;
	logic  pins_from_cells;

	// ****************************************************************
	// Test reset
	// ****************************************************************
	// Test reset pin or debug mode both hold the test logic in reset.
	assign tap_rst_n = link.trst_n & ~link.dbg_mode;

	// ****************************************************************
	// Controller next state
	// ****************************************************************
	// Standard transition table, stepped by mode select.
	function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
		tap_state_e n;
		n = s;
		case (s)
			ST_TLR:    n = tms ? ST_TLR : ST_RTI;
			ST_RTI:    n = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: n = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: n = tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
			default:   n = ST_TLR;
		endcase
		return n;
	endfunction

	// ****************************************************************
	// Instruction decode
	// ****************************************************************
	// Decode reads only the hold stage, so a code acts from its update edge on.
	always_comb begin
		sel_bsr = 1'b0;
		sel_id = 1'b0;
		func_reset = 1'b0;
		pins_highz = 1'b0;
		pins_from_cells = 1'b0;
		case (neg.ir_hold)
			INS_EXTEST: begin
				sel_bsr = 1'b1;
				func_reset = 1'b1;
				pins_from_cells = 1'b1;
			end
			INS_IDCODE: sel_id = 1'b1;
			INS_SAMPLE: sel_bsr = 1'b1;
			INS_HIGHZ: begin
				func_reset = 1'b1;
				pins_highz = 1'b1;
			end
			INS_CLAMP: begin
				func_reset = 1'b1;
				pins_from_cells = 1'b1;
			end
			default: ;
		endcase
	end

	// ****************************************************************
	// Rising test clock: controller and shift stages
	// ****************************************************************
	// Mode select and data in are sampled on the rising test clock.
	always_comb begin
		next_pos = pos;
		next_pos.state = tap_next(pos.state, link.tms);
		case (pos.state)
			ST_TLR: next_pos.ir_shift = IR_RESET;
			ST_CAP_IR: next_pos.ir_shift = IR_CAPTURE;
			ST_SH_IR: next_pos.ir_shift = {link.tdi, pos.ir_shift[IR_WIDTH-1:1]};
			ST_CAP_DR: begin
				if (sel_id) begin
					next_pos.id_shift = ID_CODE;
				end
				next_pos.bypass = 1'b0;
			end
			ST_SH_DR: begin
				if (sel_id) begin
					next_pos.id_shift = {link.tdi, pos.id_shift[ID_WIDTH-1:1]};
				end
				next_pos.bypass = link.tdi;
			end
			default: ;
		endcase
	end

	// The whole test side runs on the test clock alone.
	always_ff @(posedge link.tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			pos <= POS_RESET;
		end else begin
			pos <= next_pos;
		end
	end

	// ****************************************************************
	// Falling test clock: hold stage and data out
	// ****************************************************************
	// Data out and the instruction hold stage change on the falling edge.
	always_comb begin
		next_neg = neg;
		next_neg.tdo_oe = (pos.state == ST_SH_IR) || (pos.state == ST_SH_DR);
		if (pos.state == ST_SH_IR) begin
			next_neg.tdo = pos.ir_shift[0];
		end else if (pos.state == ST_SH_DR) begin
			next_neg.tdo = sel_bsr ? i_bsr_tdo : (sel_id ? pos.id_shift[0] : pos.bypass);
		end
		if (pos.state == ST_UPD_IR) begin
			next_neg.ir_hold = pos.ir_shift;
		end else if (pos.state == ST_TLR) begin
			next_neg.ir_hold = IR_RESET;
		end
	end

	always_ff @(negedge link.tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			neg <= NEG_RESET;
		end else begin
			neg <= next_neg;
		end
	end

	// ****************************************************************
	// Pin control into the system clock domain
	// ****************************************************************
	// Two-stage synchronisers carry the pin-control levels to the system side.
	always_comb begin
		next_core.meta = {pins_from_cells, pins_highz, func_reset};
		next_core.stable = core.meta;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			core <= '0;
		end else begin
			core <= next_core;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Boundary cells sit outside and share the test clock.
	assign link.tdo          = neg.tdo;
	assign link.tdo_oe       = neg.tdo_oe;
	assign o_bsr_tdi         = link.tdi;
	assign o_bsr_select      = sel_bsr;
	assign o_bsr_capture     = sel_bsr && (pos.state == ST_CAP_DR);
	assign o_bsr_shift       = sel_bsr && (pos.state == ST_SH_DR);
	assign o_bsr_update      = sel_bsr && (pos.state == ST_UPD_DR);
	assign o_func_reset      = core.stable[0];
	assign o_pins_highz      = core.stable[1];
	assign o_pins_from_cells = core.stable[2];

endmodule

// [rtl/tap_host.sv]
// Tester end: makes the test clock and walks the controller through scans.
`timescale 1ns/1ps
module tap_host
	import tap_pkg::*;
#(
	parameter int HALF_CYCLES = TCK_HALF_CYCLES
) (
	jtag_link_if.host  link,
	input  wire logic          i_core_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_valid,
	input  wire tap_op_e       i_op,
	input  wire logic [4:0]    i_len_m1,
	input  wire logic [31:0]   i_data,
	input  wire logic          i_trst,
	input  wire logic          i_debug_mode,
	output logic               o_ready,
	output logic               o_done,
	output logic [31:0]        o_rdata
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// Data out is read through a synchroniser and needs settling time.
	if (HALF_CYCLES < 3 || HALF_CYCLES > 127) begin : g_bad_half
		$error("Half test clock period must be 3 to 127 cycles.");
	end

	localparam logic [7:0] HALF = 8'(HALF_CYCLES);
	localparam logic [7:0] LAST = 8'(2 * HALF_CYCLES - 1);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic {
		H_IDLE, H_RUN
	} host_state_e;

	typedef struct packed {
		host_state_e   state;
		logic          is_reset;
		logic [2:0]    pre;
		logic [3:0]    pre_tms;
		logic [4:0]    len_m1;
		logic [7:0]    cnt;
		logic [5:0]    step;
		logic [31:0]   wdata;
		logic [31:0]   rdata;
		logic          tck;
		logic          tms;
		logic          tdi;
		logic          done;
		logic          trst;
		logic          dbg;
		logic          tdo_meta;
		logic          tdo_sync;
	} host_s;

	host_s       r;
	host_s       next_r;
	logic [5:0]  last_shift;
	logic [5:0]  end_step;
	logic        step_tms;
	logic        in_shift;
	logic [5:0]  bit_idx;

	// ****************************************************************
	// Per-step mode select and data
	// ****************************************************************
	// Scans start and end in run-test idle; reset holds select high five steps.
	always_comb begin
		last_shift = 6'(r.pre) + 6'(r.len_m1);
		end_step = r.is_reset ? RESET_LAST_STEP : last_shift + 6'h02;
		bit_idx = r.step - 6'(r.pre);
		in_shift = !r.is_reset && (r.step >= 6'(r.pre)) && (r.step <= last_shift);
		if (r.is_reset) begin
			step_tms = (r.step < 6'(RESET_HIGH_STEPS));
		end else if (r.step < 6'(r.pre)) begin
			step_tms = r.pre_tms[r.step[1:0]];
		end else if (r.step <= last_shift) begin
			step_tms = (r.step == last_shift);
		end else begin
			step_tms = (r.step == last_shift + 6'h01);
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Select and data change while the clock is low, ahead of its rise.
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.trst = i_trst;
		next_r.dbg = i_debug_mode;
		next_r.tdo_meta = link.tdo_line;
		next_r.tdo_sync = r.tdo_meta;
		case (r.state)
			H_IDLE: begin
				if (i_valid) begin
					next_r.state = H_RUN;
					next_r.is_reset = (i_op == OP_RESET);
					next_r.pre = (i_op == OP_IR) ? PRE_STEPS_IR : PRE_STEPS_DR;
					next_r.pre_tms = (i_op == OP_IR) ? PRE_TMS_IR : PRE_TMS_DR;
					next_r.len_m1 = i_len_m1;
					next_r.wdata = i_data;
					next_r.rdata = '0;
					next_r.cnt = '0;
					next_r.step = '0;
				end
			end
			H_RUN: begin
				next_r.cnt = r.cnt + 8'h01;
				if (r.cnt == 8'h00) begin
					next_r.tms = step_tms;
					next_r.tdi = in_shift ? r.wdata[bit_idx[4:0]] : 1'b1;
				end
				if (r.cnt == HALF) begin
					next_r.tck = 1'b1;
				end
				if (r.cnt == LAST) begin
					next_r.tck = 1'b0;
					next_r.cnt = '0;
					next_r.step = r.step + 6'h01;
					if (in_shift) begin
						next_r.rdata = {r.tdo_sync, r.rdata[31:1]};
					end
					if (r.step == end_step) begin
						next_r.state = H_IDLE;
						next_r.done = 1'b1;
						next_r.rdata = r.rdata >> (5'h1F - r.len_m1);
					end
				end
			end
			default: next_r.state = H_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '{state: H_IDLE, tms: 1'b1, tdi: 1'b1, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign link.tck      = r.tck;
	assign link.tms      = r.tms;
	assign link.tdi      = r.tdi;
	assign link.trst_n   = ~r.trst;
	assign link.dbg_mode = r.dbg;
	assign o_ready       = (r.state == H_IDLE);
	assign o_done        = r.done;
	assign o_rdata       = r.rdata;

endmodule

// [test/tap_link_sva.sv]
// Concurrent checks on the test access port wires between tester and device.
`timescale 1ns/1ps
module tap_link_sva
	import tap_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	input wire logic dbg_mode,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic tdo_line
);
	// *****************
	// Reference controller
	// *****************
	logic       tlr_n;
	logic       byp;
	tap_state_e st;
	logic [2:0] ir;
	logic [2:0] hold;

	// Test logic sits in reset while test reset is low or debug mode is on.
	assign tlr_n = trst_n & ~dbg_mode;
	assign byp   = hold[1] | (hold[2] & hold[0]);

	// Next controller state for one rising test clock.
	function automatic tap_state_e step(tap_state_e s, logic m);
		case (s)
			ST_TLR:              step = m ? ST_TLR : ST_RTI;
			ST_RTI:              step = m ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR:           step = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR, ST_SH_DR: step = m ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR:           step = m ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR:           step = m ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR:           step = m ? ST_UPD_DR : ST_SH_DR;
			ST_SEL_IR:           step = m ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR, ST_SH_IR: step = m ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR:           step = m ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR:           step = m ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR:           step = m ? ST_UPD_IR : ST_SH_IR;
			default:             step = m ? ST_SEL_DR : ST_RTI;
		endcase
	endfunction

	// Controller state and instruction shift stage follow the rising edge.
	always_ff @(posedge tck or negedge tlr_n) begin
		if (!tlr_n) begin
			st <= ST_TLR;
			ir <= IR_RESET;
		end else begin
			st <= step(st, tms);
			if (st == ST_CAP_IR) begin
				ir <= IR_CAPTURE;
			end else if (st == ST_SH_IR) begin
				ir <= {tdi, ir[2:1]};
			end
		end
	end

	// Active instruction changes on the falling edge only.
	always_ff @(negedge tck or negedge tlr_n) begin
		if (!tlr_n) begin
			hold <= IR_RESET;
		end else if (st == ST_UPD_IR) begin
			hold <= ir;
		end else if (st == ST_TLR) begin
			hold <= IR_RESET;
		end
	end

	// *****************
	// Assertions
	// *****************
	a_oe_in_shift: assert property (@(posedge tck) disable iff (!tlr_n)
		tdo_oe == (st == ST_SH_DR || st == ST_SH_IR)) else $error("data out enable wrong state");
	a_tdo_fall_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || !tlr_n)
		(tck && $past(tck)) |-> $stable(tdo)) else $error("data out moved while clock high");
	a_tms_steady: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(tck && $past(tck)) |-> $stable(tms)) else $error("mode select moved while clock high");
	a_tdi_steady: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(tck && $past(tck)) |-> $stable(tdi)) else $error("data in moved while clock high");
	a_reset_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!tlr_n |-> !tdo_oe) else $error("data out driven in reset");
	a_ir_capture: assert property (@(posedge tck) disable iff (!tlr_n)
		(st == ST_SH_IR && $past(st) == ST_CAP_IR) |-> tdo_line ##1
		(st != ST_SH_IR || !tdo_line)) else $error("instruction capture not 001");
	a_id_first_one: assert property (@(posedge tck) disable iff (!tlr_n)
		(st == ST_SH_DR && $past(st) == ST_CAP_DR && hold == INS_IDCODE) |-> tdo_line)
		else $error("identification first bit not one");
	a_byp_first_zero: assert property (@(posedge tck) disable iff (!tlr_n)
		(st == ST_SH_DR && $past(st) == ST_CAP_DR && byp) |-> !tdo_line)
		else $error("bypass first bit not zero");
	a_byp_one_stage: assert property (@(posedge tck) disable iff (!tlr_n)
		(st == ST_SH_DR && $past(st) == ST_SH_DR && byp) |-> tdo_line == $past(tdi))
		else $error("bypass path not one stage");
endmodule

// [test/boundary_scan_tap_logic_tb_top.sv]
// Self-checking bench joining the tester end and the device end over one link.
`timescale 1ns/1ps
module boundary_scan_tap_logic_tb_top
	import tap_pkg::*;
;
	// *****************
	// Signals and instances
	// *****************
	logic        i_core_clk;
	logic        i_rst_n;
	logic        valid;
	logic        trst;
	logic        debug_mode;
	logic        bsr_cell = 1'b0;
	tap_op_e     op;
	logic [4:0]  len_m1;
	logic [31:0] data;
	logic        ready;
	logic        done;
	logic [31:0] rdata;
	logic        bsr_tdi;
	logic        bsr_select;
	logic        bsr_capture;
	logic        bsr_shift;
	logic        bsr_update;
	logic        func_reset;
	logic        pins_highz;
	logic        pins_from_cells;
	int          errors = 0;
	int          samples_checked = 0;
	int          bsr_updates = 0;

	jtag_link_if link();

	tap_host i_tap_host (.link(link), .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_valid(valid), .i_op(op), .i_len_m1(len_m1), .i_data(data), .i_trst(trst),
		.i_debug_mode(debug_mode), .o_ready(ready), .o_done(done), .o_rdata(rdata));

	tap_device i_tap_device (.link(link), .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_bsr_tdo(bsr_cell), .o_bsr_tdi(bsr_tdi), .o_bsr_select(bsr_select),
		.o_bsr_capture(bsr_capture), .o_bsr_shift(bsr_shift), .o_bsr_update(bsr_update),
		.o_func_reset(func_reset), .o_pins_highz(pins_highz),
		.o_pins_from_cells(pins_from_cells));

	tap_link_sva i_tap_link_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.tck(link.tck), .tms(link.tms), .tdi(link.tdi), .trst_n(link.trst_n),
		.dbg_mode(link.dbg_mode), .tdo(link.tdo), .tdo_oe(link.tdo_oe),
		.tdo_line(link.tdo_line));

	// One external boundary cell: captures one, then shifts the serial input.
	// Update strobes are counted so that each scan can be judged.
	always @(posedge link.tck) begin
		if (bsr_update) begin
			bsr_updates <= bsr_updates + 1;
		end
		if (bsr_shift) begin
			bsr_cell <= bsr_tdi;
		end else if (bsr_capture) begin
			bsr_cell <= 1'b1;
		end
	end

	// Core clock of 10 ns.
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	// *****************
	// Shared tasks
	// *****************
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One host request; the scan length in core cycles is fixed by the step count.
	task automatic run(tap_op_e o, logic [4:0] l, logic [31:0] d);
		int n;
		int steps;
		n = 0;
		steps = (o == OP_RESET) ? 6 : ((o == OP_IR) ? 6 : 5) + int'(l) + 1;
		@(posedge i_core_clk);
		valid <= 1'b1;
		op <= o;
		len_m1 <= l;
		data <= d;
		@(posedge i_core_clk);
		valid <= 1'b0;
		#1;
		check("ready after take", 32'h0, 32'(ready));
		while (done !== 1'b1 && n < 2000) begin
			@(posedge i_core_clk);
			#1;
			n++;
		end
		check("scan cycles", 32'(steps * 2 * TCK_HALF_CYCLES), 32'(n));
		check("ready at done", 32'h1, 32'(ready));
	endtask

	// Pin control for instruction c, after the synchronisers settle.
	task automatic check_pins(logic [2:0] c);
		repeat (4) @(posedge i_core_clk);
		#1;
		check("func reset", 32'(c inside {3'h0, 3'h5, 3'h6}), 32'(func_reset));
		check("pins highz", 32'(c == INS_HIGHZ), 32'(pins_highz));
		check("pins from cells", 32'(c inside {3'h0, 3'h6}), 32'(pins_from_cells));
		check("scan select", 32'(c inside {3'h0, 3'h4}), 32'(bsr_select));
	endtask

	// *****************
	// Scenarios
	// *****************
	task automatic t_codes;
		logic [31:0] exp;
		int          upd;
		for (int c = 0; c < 8; c++) begin
			run(OP_IR, 5'h02, 32'(c));
			check("ir capture", 32'(IR_CAPTURE), rdata);
			check_pins(3'(c));
			exp = (c == 1) ? {28'h0, ID_DEFAULT[3:0]} : ((c == 0 || c == 4) ? 32'h5 : 32'h4);
			upd = bsr_updates;
			run(OP_DR, 5'h03, 32'hA);
			check("dr bits", exp, rdata);
			check("scan updates", 32'((c == 0 || c == 4) ? 1 : 0), 32'(bsr_updates - upd));
			check_pins(3'(c));
		end
	endtask

	task automatic t_trst;
		run(OP_IR, 5'h02, 32'(INS_HIGHZ));
		@(posedge i_core_clk);
		trst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		trst <= 1'b0;
		check_pins(INS_IDCODE);
		run(OP_RESET, 5'h00, 32'h0);
		run(OP_DR, 5'h1F, 32'h0);
		check("id after test reset", ID_DEFAULT, rdata);
	endtask

	task automatic t_debug;
		run(OP_IR, 5'h02, 32'(INS_EXTEST));
		check("func reset before debug", 32'h1, 32'(func_reset));
		@(posedge i_core_clk);
		debug_mode <= 1'b1;
		check_pins(INS_IDCODE);
		run(OP_DR, 5'h03, 32'h0);
		check("undriven line", 32'hF, rdata);
		@(posedge i_core_clk);
		debug_mode <= 1'b0;
		run(OP_RESET, 5'h00, 32'h0);
		run(OP_DR, 5'h1F, 32'h0);
		check("id after debug", ID_DEFAULT, rdata);
	endtask

	task automatic t_tms_reset;
		run(OP_IR, 5'h02, 32'(INS_BYPASS));
		run(OP_RESET, 5'h00, 32'h0);
		run(OP_DR, 5'h1F, 32'h0);
		check("id after mode reset", ID_DEFAULT, rdata);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run of some 5200 core cycles.
	initial begin
		#500000;
		errors++;
		stop_test();
	end

	// Main sequence: reset, then every scenario.
	initial begin
		i_rst_n = 1'b0;
		valid = 1'b0;
		op = OP_RESET;
		len_m1 = 5'h00;
		data = 32'h0;
		trst = 1'b1;
		debug_mode = 1'b0;
		repeat (5) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		trst <= 1'b0;
		run(OP_RESET, 5'h00, 32'h0);
		t_codes();
		t_trst();
		t_debug();
		t_tms_reset();
		stop_test();
	end
endmodule
